// ==== common/btob_consts.vh ====
// Constants for the bit toggle and overflow branch execution block.
`ifndef BTOB_CONSTS_VH
`define BTOB_CONSTS_VH

// Register byte offsets on the Wishbone slave.
`define BTOB_REG_CTRL      8'h00
`define BTOB_REG_BANK      8'h04
`define BTOB_REG_INSTR     8'h08
`define BTOB_REG_PC        8'h0c
`define BTOB_REG_INDEX     8'h10
`define BTOB_REG_STATUS    8'h14
`define BTOB_REG_EFFADDR   8'h18

// Control register fields.
`define BTOB_CTRL_EXT_BIT  0
`define BTOB_CTRL_GO_BIT   1
`define BTOB_CTRL_OVF_BIT  2

// Status register fields; done and illegal are sticky, write one to clear.
`define BTOB_STAT_BUSY_BIT 0
`define BTOB_STAT_DONE_BIT 1
`define BTOB_STAT_TAKEN_BIT 2
`define BTOB_STAT_ILL_BIT  3

// Instruction encodings.
`define BTOB_OP_TOGGLE     4'h7
`define BTOB_OP_BRANCH_OVF 8'he4

// Addressing constants.
`define BTOB_INDEXED_MAX   8'h5f
`define BTOB_ACCESS_SPLIT  8'h60
`define BTOB_ACCESS_LO     4'h0
`define BTOB_ACCESS_HI     4'hf

// Phase numbering within one instruction cycle.
`define BTOB_Q1            2'h0
`define BTOB_Q2            2'h1
`define BTOB_Q3            2'h2
`define BTOB_Q4            2'h3

// Reset values and the program counter step.
`define BTOB_PC_RESET      21'h000000
`define BTOB_INSTR_RESET   16'h0000
`define BTOB_PC_STEP       21'h000002

`endif

// ==== hdl/btob_phase_gen.v ====
// Four-phase sequencer that splits each instruction cycle into four clocks.
`timescale 1ns/100ps
`default_nettype none
`include "btob_consts.vh"

module btob_phase_gen
(
   input  wire       clk_sys_in,
   input  wire       rst_in,
   output wire [1:0] phase_out,
   output wire       q4_out
);

   reg [1:0] phase_r;

   always @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
         phase_r <= `BTOB_Q1;
      else
         phase_r <= phase_r + 2'h1;
   end

   assign phase_out = phase_r;
   assign q4_out    = (phase_r == `BTOB_Q4);

endmodule // btob_phase_gen

`default_nettype wire

// ==== hdl/btob_core.v ====
// Execution unit for the bit toggle and branch on overflow instructions.
//
// Contract
// - Toggle inverts only the selected data bit.
// - Bank flag picks access bank or bank.
// - Extended mode, small offsets index from base.
// - Toggle: decode, read, modify, write; one cycle.
// - Branch only when overflow set; flags untouched.
// - Taken target is address plus two plus 2n.
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "btob_consts.vh"

module btob_core
(
   input  wire        clk_sys_in,
   input  wire        rst_in,
   input  wire        wb_cyc_in,
   input  wire        wb_stb_in,
   input  wire        wb_we_in,
   input  wire [7:0]  wb_adr_in,
   input  wire [3:0]  wb_sel_in,
   input  wire [31:0] wb_dat_in,
   output wire [31:0] wb_dat_out,
   output wire        wb_ack_out,
   output wire [11:0] dmem_addr_out,
   output wire        dmem_rd_out,
   output wire        dmem_wr_out,
   output wire [7:0]  dmem_wdata_out,
   input  wire [7:0]  dmem_rdata_in
);

   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_EXEC  = 2'h1;
   localparam [1:0] ST_FLUSH = 2'h2;

   reg  [1:0]  state_r;
   reg         ack_r;
   reg  [31:0] rdata_r;
   reg         ext_en_r;
   reg         go_pend_r;
   reg         ovf_r;
   reg  [3:0]  bank_r;
   reg  [15:0] instr_r;
   reg  [20:0] pc_r;
   reg  [11:0] index_r;
   reg         done_r;
   reg         taken_r;
   reg         ill_r;
   reg  [11:0] addr_r;
   reg         rd_r;
   reg         wr_r;
   reg  [7:0]  wdata_r;
   reg  [11:0] eff_addr_nxt;
   reg  [20:0] pc_nxt;
   reg  [31:0] rdata_nxt;
   reg  [31:0] byte_mask;

   wire [1:0]  phase;
   wire        q4;
   wire        is_toggle;
   wire        is_branch;
   wire        branch_go;
   wire [2:0]  bit_sel;
   wire        bank_flag;
   wire [7:0]  file_addr;
   wire [20:0] offset_x2;
   wire        bus_req;
   wire        wr_now;
   wire        busy;
   wire        finish;
   wire        clr_done;
   wire        clr_ill;

   btob_phase_gen u_phase
   (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .phase_out  (phase),
      .q4_out     (q4)
   );

   assign is_toggle = (instr_r[15:12] == `BTOB_OP_TOGGLE);
   assign is_branch = (instr_r[15:8] == `BTOB_OP_BRANCH_OVF);
   // The overflow flag is only read here, so the branch never changes it.
   assign branch_go = is_branch & ovf_r;
   assign bit_sel   = instr_r[11:9];
   assign bank_flag = instr_r[8];
   assign file_addr = instr_r[7:0];
   // Offset sign-extended and doubled; wraps within the 21-bit counter.
   assign offset_x2 = {{12{instr_r[7]}}, instr_r[7:0], 1'b0};
   assign busy      = (state_r != ST_IDLE);

   // Effective data address for the toggle operand.
   always @*
   begin
      eff_addr_nxt = {bank_r, file_addr};
      if (bank_flag)
         eff_addr_nxt = {bank_r, file_addr};
      else if (ext_en_r && (file_addr <= `BTOB_INDEXED_MAX))
         eff_addr_nxt = index_r + {4'h0, file_addr};
      else if (file_addr < `BTOB_ACCESS_SPLIT)
         eff_addr_nxt = {`BTOB_ACCESS_LO, file_addr};
      else
         eff_addr_nxt = {`BTOB_ACCESS_HI, file_addr};
   end

   // Next program counter at the end of the instruction cycle.
   always @*
   begin
      if (branch_go)
         pc_nxt = pc_r + `BTOB_PC_STEP + offset_x2;
      else
         pc_nxt = pc_r + `BTOB_PC_STEP;
   end

   // Execution sequencer aligned to the four phases.
   assign finish = ((state_r == ST_EXEC) && q4 && !branch_go)
                 || ((state_r == ST_FLUSH) && q4);

   always @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_r <= ST_IDLE;
         addr_r  <= 12'h000;
         rd_r    <= 1'b0;
         wr_r    <= 1'b0;
         wdata_r <= 8'h00;
         pc_r    <= `BTOB_PC_RESET;
         taken_r <= 1'b0;
      end
      else
      begin
         case (state_r)
            ST_IDLE:
            begin
               rd_r <= 1'b0;
               wr_r <= 1'b0;
               // Starting on the last phase keeps each cycle Q1 aligned.
               if (go_pend_r && q4)
                  state_r <= ST_EXEC;
            end
            ST_EXEC:
            begin
               case (phase)
                  `BTOB_Q1:
                  begin
                     if (is_toggle)
                     begin
                        addr_r <= eff_addr_nxt;
                        rd_r   <= 1'b1;
                     end
                  end
                  `BTOB_Q2:
                     rd_r <= 1'b0;
                  `BTOB_Q3:
                  begin
                     if (is_toggle)
                     begin
                        wdata_r <= dmem_rdata_in ^ (8'h01 << bit_sel);
                        wr_r    <= 1'b1;
                     end
                  end
                  default:
                  begin
                     wr_r    <= 1'b0;
                     pc_r    <= pc_nxt;
                     taken_r <= branch_go;
                     if (branch_go)
                        state_r <= ST_FLUSH;
                     else
                        state_r <= ST_IDLE;
                  end
               endcase
            end
            ST_FLUSH:
            begin
               // The prefetched word is dropped; this cycle does nothing.
               rd_r <= 1'b0;
               wr_r <= 1'b0;
               if (q4)
                  state_r <= ST_IDLE;
            end
            default:
               state_r <= ST_IDLE;
         endcase
         if (!busy && wr_now && (wb_adr_in == `BTOB_REG_PC))
            pc_r <= wb_dat_in[20:0] & byte_mask[20:0] | pc_r & ~byte_mask[20:0];
      end
   end

   // Wishbone slave: ack one clock after the strobe, write at the ack edge.
   assign bus_req  = wb_cyc_in & wb_stb_in;
   assign wr_now   = bus_req & wb_we_in & ack_r;
   assign clr_done = wr_now && (wb_adr_in == `BTOB_REG_STATUS) && wb_sel_in[0]
                     && wb_dat_in[`BTOB_STAT_DONE_BIT];
   assign clr_ill  = wr_now && (wb_adr_in == `BTOB_REG_STATUS) && wb_sel_in[0]
                     && wb_dat_in[`BTOB_STAT_ILL_BIT];

   always @*
   begin
      byte_mask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                   {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
   end

   always @*
   begin
      rdata_nxt = 32'h00000000;
      case (wb_adr_in)
         `BTOB_REG_CTRL:
         begin
            rdata_nxt[`BTOB_CTRL_EXT_BIT] = ext_en_r;
            rdata_nxt[`BTOB_CTRL_GO_BIT]  = go_pend_r;
            rdata_nxt[`BTOB_CTRL_OVF_BIT] = ovf_r;
         end
         `BTOB_REG_BANK:    rdata_nxt[3:0]   = bank_r;
         `BTOB_REG_INSTR:   rdata_nxt[15:0]  = instr_r;
         `BTOB_REG_PC:      rdata_nxt[20:0]  = pc_r;
         `BTOB_REG_INDEX:   rdata_nxt[11:0]  = index_r;
         `BTOB_REG_STATUS:
         begin
            rdata_nxt[`BTOB_STAT_BUSY_BIT]  = busy;
            rdata_nxt[`BTOB_STAT_DONE_BIT]  = done_r;
            rdata_nxt[`BTOB_STAT_TAKEN_BIT] = taken_r;
            rdata_nxt[`BTOB_STAT_ILL_BIT]   = ill_r;
         end
         `BTOB_REG_EFFADDR: rdata_nxt[11:0]  = addr_r;
         default:           rdata_nxt        = 32'h00000000;
      endcase
   end

   always @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ack_r     <= 1'b0;
         rdata_r   <= 32'h00000000;
         ext_en_r  <= 1'b0;
         go_pend_r <= 1'b0;
         ovf_r     <= 1'b0;
         bank_r    <= 4'h0;
         instr_r   <= `BTOB_INSTR_RESET;
         index_r   <= 12'h000;
         done_r    <= 1'b0;
         ill_r     <= 1'b0;
      end
      else
      begin
         ack_r <= bus_req & ~ack_r;
         if (bus_req & ~ack_r)
            rdata_r <= rdata_nxt;
         // Start request is consumed as the sequencer leaves idle.
         if (state_r == ST_IDLE && go_pend_r && q4)
            go_pend_r <= 1'b0;
         // Operands stay frozen while an instruction runs.
         if (wr_now && !busy)
         begin
            case (wb_adr_in)
               `BTOB_REG_CTRL:
               begin
                  if (wb_sel_in[0])
                  begin
                     ext_en_r  <= wb_dat_in[`BTOB_CTRL_EXT_BIT];
                     ovf_r     <= wb_dat_in[`BTOB_CTRL_OVF_BIT];
                     go_pend_r <= wb_dat_in[`BTOB_CTRL_GO_BIT];
                  end
               end
               `BTOB_REG_BANK:
                  if (wb_sel_in[0])
                     bank_r <= wb_dat_in[3:0];
               `BTOB_REG_INSTR:
                  instr_r <= wb_dat_in[15:0] & byte_mask[15:0]
                           | instr_r & ~byte_mask[15:0];
               `BTOB_REG_INDEX:
                  index_r <= wb_dat_in[11:0] & byte_mask[11:0]
                           | index_r & ~byte_mask[11:0];
               default:
                  ;
            endcase
         end
         // Hardware set wins over a software clear in the same clock.
         if (finish)
            done_r <= 1'b1;
         else if (clr_done)
            done_r <= 1'b0;
         if (state_r == ST_EXEC && q4 && !is_toggle && !is_branch)
            ill_r <= 1'b1;
         else if (clr_ill)
            ill_r <= 1'b0;
      end
   end

   assign wb_ack_out     = ack_r;
   assign wb_dat_out     = rdata_r;
   assign dmem_addr_out  = addr_r;
   assign dmem_rd_out    = rd_r;
   assign dmem_wr_out    = wr_r;
   assign dmem_wdata_out = wdata_r;

endmodule // btob_core

`default_nettype wire

// ==== dv/btob_core_props.sv ====
// Assertion checker for the toggle and branch execution block.
`timescale 1ns/100ps
`default_nettype none
module btob_core_props
(
   input wire logic        clk_sys_in,
   input wire logic        rst_in,
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_ack_out,
   input wire logic        dmem_rd_out,
   input wire logic        dmem_wr_out,
   input wire logic [11:0] dmem_addr_out,
   input wire logic [7:0]  dmem_wdata_out,
   input wire logic [7:0]  dmem_rdata_in
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("bus ack held too long");
   ack_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("bus request not answered");
   rd_pulse_a: assert property (dmem_rd_out |=> !dmem_rd_out)
      else $error("read strobe too long");
   rd_then_wr_a: assert property (dmem_rd_out |-> ##2 dmem_wr_out)
      else $error("write back missing");
   wr_cause_a: assert property (dmem_wr_out |-> $past(dmem_rd_out, 2))
      else $error("write without read");
   wr_gap_a: assert property (dmem_wr_out |=> !dmem_wr_out [*3])
      else $error("second write in one cycle");
   same_byte_a: assert property (dmem_wr_out |-> dmem_addr_out == $past(dmem_addr_out, 2))
      else $error("write back to other byte");
   one_bit_a: assert property (dmem_wr_out |->
      $countones(dmem_wdata_out ^ $past(dmem_rdata_in)) == 1)
      else $error("toggle changed not one bit");
   rd_wr_apart_a: assert property (!(dmem_rd_out && dmem_wr_out))
      else $error("read and write strobes overlap");
   cover property (dmem_wr_out);
   cover property (dmem_rd_out);
   cover property (wb_ack_out);
endmodule // btob_core_props
bind btob_core btob_core_props u_props
(
   .clk_sys_in     (clk_sys_in),
   .rst_in         (rst_in),
   .wb_cyc_in      (wb_cyc_in),
   .wb_stb_in      (wb_stb_in),
   .wb_ack_out     (wb_ack_out),
   .dmem_rd_out    (dmem_rd_out),
   .dmem_wr_out    (dmem_wr_out),
   .dmem_addr_out  (dmem_addr_out),
   .dmem_wdata_out (dmem_wdata_out),
   .dmem_rdata_in  (dmem_rdata_in)
);
`default_nettype wire

// ==== dv/btob_core_bench.sv ====
// Self-checking bench for the toggle and branch execution block.
`timescale 1ns/100ps
`default_nettype none
`include "btob_consts.vh"
module btob_core_bench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [31:0] q;
   logic [31:0] rdat;
   logic        ack;
   logic [11:0] maddr;
   logic        mrd;
   logic        mwr;
   logic [7:0]  mwd;
   logic [7:0]  mrdat = 8'h00;
   logic [7:0]  mem [0:4095];
   int          mismatches = 0;
   int          checks_done = 0;

   btob_core DUT
   (
      .clk_sys_in     (clk),
      .rst_in         (rst),
      .wb_cyc_in      (cyc),
      .wb_stb_in      (stb),
      .wb_we_in       (we),
      .wb_adr_in      (adr),
      .wb_sel_in      (4'hf),
      .wb_dat_in      (dat),
      .wb_dat_out     (rdat),
      .wb_ack_out     (ack),
      .dmem_addr_out  (maddr),
      .dmem_rd_out    (mrd),
      .dmem_wr_out    (mwr),
      .dmem_wdata_out (mwd),
      .dmem_rdata_in  (mrdat)
   );

   initial
      forever #2.5 clk = ~clk;

   // Synchronous memory, so read data lands one clock after the strobe.
   always @(posedge clk)
   begin
      if (mrd)
         mrdat <= mem[maddr];
      if (mwr)
         mem[maddr] <= mwd;
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Ack is read before this edge's updates land, so it is the sampled value.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1)
      begin
         mismatches++;
         print_verdict;
      end
   endtask

   task automatic run(input logic [15:0] ins, input logic [2:0] ctl, input logic [20:0] pc,
                      input logic [20:0] epc, input logic [31:0] m, input logic [3:0] st);
      int n;
      wb(1'b1, `BTOB_REG_PC, {11'h0, pc});
      wb(1'b1, `BTOB_REG_INSTR, {16'h0, ins});
      wb(1'b1, `BTOB_REG_CTRL, {29'h0, ctl | 3'h2});
      n = 0;
      do
      begin
         wb(1'b0, `BTOB_REG_STATUS, 32'h0);
         n++;
      end
      while (q[1] !== 1'b1 && n < 40);
      chk("status", q & m, {28'h0, st});
      if (q[1] !== 1'b1)
         print_verdict;
      wb(1'b1, `BTOB_REG_STATUS, 32'ha);
      wb(1'b0, `BTOB_REG_PC, 32'h0);
      chk("pc", q, {11'h0, epc});
   endtask

   task automatic tog(input logic a, input logic [2:0] b, input logic [7:0] f,
                      input logic [3:0] bk, input logic ext, input logic [11:0] ix,
                      input logic [11:0] ea);
      mem[ea] = 8'h75;
      wb(1'b1, `BTOB_REG_BANK, {28'h0, bk});
      wb(1'b1, `BTOB_REG_INDEX, {20'h0, ix});
      run({`BTOB_OP_TOGGLE, b, a, f}, {2'b00, ext}, 21'h40, 21'h42, 32'hb, 4'h2);
      chk("mem", mem[ea], 8'h75 ^ (8'h01 << b));
      wb(1'b0, `BTOB_REG_EFFADDR, 32'h0);
      chk("addr", q, ea);
   endtask

   task automatic sc_regs;
      wb(1'b0, `BTOB_REG_PC, 32'h0);
      chk("pc reset", q, 32'h0);
      wb(1'b1, 8'h1c, 32'hffffffff);
      wb(1'b0, 8'h1c, 32'h0);
      chk("unmapped", q, 32'h0);
      // An unknown opcode runs as a no-op and flags itself illegal.
      run(16'h0000, 3'h0, 21'h80, 21'h82, 32'hb, 4'ha);
   endtask

   task automatic sc_toggle;
      tog(1'b1, 3'h4, 8'h25, 4'h3, 1'b1, 12'h200, 12'h325);
      tog(1'b0, 3'h7, 8'h5f, 4'h3, 1'b1, 12'h200, 12'h25f);
      tog(1'b0, 3'h0, 8'h60, 4'h3, 1'b1, 12'h200, 12'hf60);
      tog(1'b0, 3'h2, 8'h10, 4'h3, 1'b0, 12'h200, 12'h010);
   endtask

   // Both offset extremes catch a sign extension or scaling slip.
   task automatic sc_branch;
      run({`BTOB_OP_BRANCH_OVF, 8'h80}, 3'h4, 21'h100, 21'h2, 32'hf, 4'h6);
      run({`BTOB_OP_BRANCH_OVF, 8'h7f}, 3'h4, 21'h1000, 21'h1100, 32'hf, 4'h6);
      wb(1'b0, `BTOB_REG_CTRL, 32'h0);
      chk("ovf kept", q[2], 32'h1);
      run({`BTOB_OP_BRANCH_OVF, 8'h7f}, 3'h0, 21'h1000, 21'h1002, 32'hf, 4'h2);
   endtask

   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      sc_regs;
      sc_toggle;
      sc_branch;
      print_verdict;
   end
endmodule // btob_core_bench
`default_nettype wire
